// ### common/tcs_pkg.sv
// Constants and types for the transmit clock select block.
// Operation
// - Rising violation bit inserts one line violation.
// - Standard bit zero is E1, one T1.
// - Align frames to 8 kHz only under PLL.
// - Protected loop timing falls back to PLL.
// - Clock loss flag sets only while protected.
// - Source codes: 00/11 loop, 01 external, 10 PLL.
// - Base rate: clock pin outputs except external.
// - High-speed backplane: clock and syncs inputs.
// - Base rate sync pins follow polarity invert.
package tcs_pkg;
  localparam logic [15:0] CTRL_ADDR = 16'h0100;
  localparam logic [15:0] SYNC_MUX_ADDR = 16'h0104;
  localparam logic [15:0] STATE_ADDR = 16'h0108;
  localparam logic [15:0] BACKPLANE_ADDR = 16'h010C;
  localparam logic [15:0] INT_STATUS_ADDR = 16'h0B00;
  localparam logic [15:0] INT_MASK_ADDR = 16'h0B04;
  localparam logic [7:0] CTRL_RESET = 8'h11;
  localparam int SYNC_POLARITY_INVERT_BIT = 4;
  localparam int CLK_LOSS_BIT = 5;
  localparam int HIGH_SPEED_BIT = 0;
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_PLL = 2'h2;
  localparam logic [1:0] SRC_LOOP_ALT = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // Pin sample vector positions.
  localparam int PIN_LOST = 0;
  localparam int PIN_REF8K = 1;
  localparam int PIN_RECCLK = 2;
  localparam int PIN_EXTCLK = 3;
  localparam int PIN_PLLCLK = 4;
  localparam int PIN_COUNT = 5;

  typedef struct packed {
    logic lcvInsert;
    logic t1Mode;
    logic syncTo8k;
    logic lossProtect;
    logic [1:0] reserved;
    logic [1:0] clockSource;
  } tcs_ctrl_type;

  typedef struct packed {
    logic serialClk;
    logic frameSync;
    logic multiframeSync;
  } tcs_pindir_type;

  typedef enum logic [1:0] {
    TIMING_LOOP,
    TIMING_EXT,
    TIMING_PLL
  } tcs_timing_type;
endpackage

// ### logic/tcs_transmit_clock_select.sv
// Transmit clock select, timing control and AXI4-Lite register slave.
`timescale 1ns/1ps
module tcs_transmit_clock_select
  import tcs_pkg::*;
#(
  parameter int ADDR_WIDTH = 16
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // AXI4-Lite write channels.
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Line and clock inputs, asynchronous to sys_clk.
  input wire logic lineRecoveryLost,
  input wire logic pllFrameRef8k,
  input wire logic recoveredClk,
  input wire logic serialClkIn,
  input wire logic pllClk,
  // Transmit timing outputs.
  output tcs_timing_type timingSource,
  output logic t1Mode,
  output logic lineCodeViolationPulse,
  output logic frameAlignPulse,
  output logic serialClkOut,
  output tcs_pindir_type pinOutputEnable,
  // Interrupt.
  output logic irq
);

  // Register and bus state.
  tcs_ctrl_type ctrl, next_ctrl;
  logic syncMux, next_syncMux;
  logic highSpeed, next_highSpeed;
  logic intStatus, next_intStatus;
  logic intMask, next_intMask;
  logic awHeld, next_awHeld;
  logic wHeld, next_wHeld;
  logic [ADDR_WIDTH-1:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic next_awReady;
  logic next_wReady;
  logic next_bValid;
  logic next_arReady;
  logic next_rValid;
  logic [1:0] next_bResp;
  logic [1:0] next_rResp;
  logic [31:0] next_rData;
  logic lcvPending, next_lcvPending;

  // Line state.
  logic [PIN_COUNT-1:0] pinMeta;
  logic [PIN_COUNT-1:0] pinSync;
  logic [PIN_COUNT-1:0] pinPrev;
  tcs_timing_type next_timingSource;
  logic next_lcvPulse;
  logic next_alignPulse;
  logic next_serialClkOut;
  logic next_irq;
  tcs_pindir_type next_pinOe;
  logic lossEvent;
  logic wrDo;

  // Two flip-flops before any logic looks at a pin.
  // Clocks are sampled like any pin, so the copy on serialClkOut is coarse at this rate.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta <= '0;
      pinSync <= '0;
      pinPrev <= '0;
    end else begin
      pinMeta <= {pllClk, serialClkIn, recoveredClk, pllFrameRef8k, lineRecoveryLost};
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  assign lossEvent = pinSync[PIN_LOST] && !pinPrev[PIN_LOST];
  assign wrDo = awHeld && wHeld && !s_axi_bvalid;

  always_comb begin
    next_ctrl = ctrl;
    next_syncMux = syncMux;
    next_highSpeed = highSpeed;
    next_intMask = intMask;
    next_intStatus = intStatus;
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bValid = s_axi_bvalid;
    next_bResp = s_axi_bresp;
    next_arReady = s_axi_arready;
    next_rValid = s_axi_rvalid;
    next_rData = s_axi_rdata;
    next_rResp = s_axi_rresp;
    next_lcvPending = 1'b0;
    // Address and data are taken in either order and held until both are present.
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
    if (wrDo) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = RESP_OKAY;
      unique case (awAddr[15:0])
        CTRL_ADDR: begin
          if (wStrb[0]) begin
            next_ctrl = tcs_ctrl_type'(wData[7:0]);
            // Only the edge counts, so a bit left at one never repeats the violation.
            next_lcvPending = wData[7] && !ctrl.lcvInsert;
          end
        end
        SYNC_MUX_ADDR: begin
          if (wStrb[0]) begin
            next_syncMux = wData[SYNC_POLARITY_INVERT_BIT];
          end
        end
        BACKPLANE_ADDR: begin
          if (wStrb[0]) begin
            next_highSpeed = wData[HIGH_SPEED_BIT];
          end
        end
        INT_MASK_ADDR: begin
          if (wStrb[0]) begin
            next_intMask = wData[CLK_LOSS_BIT];
          end
        end
        INT_STATUS_ADDR: begin
          if (wStrb[0] && wData[CLK_LOSS_BIT]) begin
            next_intStatus = 1'b0;
          end
        end
        STATE_ADDR: begin
        end
        // An unmapped word still gets an answer, so a master never stalls on it.
        default: begin
          next_bResp = RESP_SLVERR;
        end
      endcase
    end
    // A loss edge in the clearing cycle still sets the flag.
    if (lossEvent && ctrl.lossProtect) begin
      next_intStatus = 1'b1;
    end
    // One read at a time: arready drops while the answer stands.
    if (s_axi_rvalid && s_axi_rready) begin
      next_rValid = 1'b0;
      next_arReady = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arReady = 1'b0;
      next_rValid = 1'b1;
      next_rResp = RESP_OKAY;
      next_rData = ZERO_WORD;
      unique case (s_axi_araddr[15:0])
        CTRL_ADDR: next_rData[7:0] = ctrl;
        SYNC_MUX_ADDR: next_rData[SYNC_POLARITY_INVERT_BIT] = syncMux;
        BACKPLANE_ADDR: next_rData[HIGH_SPEED_BIT] = highSpeed;
        STATE_ADDR: begin
          next_rData[1:0] = timingSource;
          next_rData[2] = pinSync[PIN_LOST];
        end
        INT_STATUS_ADDR: next_rData[CLK_LOSS_BIT] = intStatus;
        INT_MASK_ADDR: next_rData[CLK_LOSS_BIT] = intMask;
        default: next_rResp = RESP_SLVERR;
      endcase
    end
    next_awReady = !next_awHeld && !next_bValid;
    next_wReady = !next_wHeld && !next_bValid;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= tcs_ctrl_type'(CTRL_RESET);
      syncMux <= 1'b0;
      highSpeed <= 1'b0;
      intStatus <= 1'b0;
      intMask <= 1'b0;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= ZERO_WORD;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= ZERO_WORD;
      s_axi_rresp <= RESP_OKAY;
      lcvPending <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      syncMux <= next_syncMux;
      highSpeed <= next_highSpeed;
      intStatus <= next_intStatus;
      intMask <= next_intMask;
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      s_axi_awready <= next_awReady;
      s_axi_wready <= next_wReady;
      s_axi_bvalid <= next_bValid;
      s_axi_bresp <= next_bResp;
      s_axi_arready <= next_arReady || (!s_axi_arready && !s_axi_rvalid && !next_rValid);
      s_axi_rvalid <= next_rValid;
      s_axi_rdata <= next_rData;
      s_axi_rresp <= next_rResp;
      lcvPending <= next_lcvPending;
    end
  end

  // Timing source selection and pin directions.
  always_comb begin
    // Defaults keep every path assigned; the fourth code of the source enum never occurs.
    next_timingSource = TIMING_LOOP;
    next_serialClkOut = 1'b0;
    next_pinOe = '0;
    unique case (ctrl.clockSource)
      SRC_EXT: next_timingSource = TIMING_EXT;
      SRC_PLL: next_timingSource = TIMING_PLL;
      SRC_LOOP, SRC_LOOP_ALT: begin
        // Falls back to the PLL only while recovery is lost, then returns.
        if (ctrl.lossProtect && pinSync[PIN_LOST]) begin
          next_timingSource = TIMING_PLL;
        end else begin
          next_timingSource = TIMING_LOOP;
        end
      end
    endcase
    unique case (next_timingSource)
      TIMING_EXT: next_serialClkOut = 1'b0;
      TIMING_PLL: next_serialClkOut = pinSync[PIN_PLLCLK];
      TIMING_LOOP: next_serialClkOut = pinSync[PIN_RECCLK];
    endcase
    if (highSpeed) begin
      next_pinOe = '0;
      next_serialClkOut = 1'b0;
    end else begin
      next_pinOe.serialClk = (next_timingSource != TIMING_EXT);
      next_pinOe.frameSync = !syncMux;
      next_pinOe.multiframeSync = !syncMux;
    end
    next_alignPulse = ctrl.syncTo8k && (next_timingSource == TIMING_PLL)
                      && pinSync[PIN_REF8K] && !pinPrev[PIN_REF8K];
    next_lcvPulse = lcvPending;
    // Taken from the next values so irq moves on the same edge as the status bit.
    next_irq = (next_intStatus && next_intMask);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      timingSource <= TIMING_EXT;
      t1Mode <= 1'b0;
      lineCodeViolationPulse <= 1'b0;
      frameAlignPulse <= 1'b0;
      serialClkOut <= 1'b0;
      pinOutputEnable <= '0;
      irq <= 1'b0;
    end else begin
      timingSource <= next_timingSource;
      t1Mode <= ctrl.t1Mode;
      lineCodeViolationPulse <= next_lcvPulse;
      frameAlignPulse <= next_alignPulse;
      serialClkOut <= next_serialClkOut;
      pinOutputEnable <= next_pinOe;
      irq <= next_irq;
    end
  end

endmodule

// ### bench/tcs_far_model.sv
// Far-side model: line and backplane clocks, loss of recovery and the 8 kHz reference.
`timescale 1ns/1ps
module tcs_far_model (
  // Controls from the bench.
  input wire logic lossReq,
  input wire logic refReq,
  // Far-side signals.
  output logic lineRecoveryLost,
  output logic pllFrameRef8k,
  output logic recoveredClk,
  output logic serialClkIn,
  output logic pllClk
);
  initial begin
    recoveredClk = 1'b0;
    serialClkIn = 1'b0;
    pllClk = 1'b0;
  end
  // The backplane always drives the serial clock, since the pin may be an input.
  always #244 serialClkIn = ~serialClkIn;
  always #250 pllClk = ~pllClk;
  // A line without recovery gives no edges, so its clock freezes.
  always #255 recoveredClk = lineRecoveryLost ? recoveredClk : ~recoveredClk;
  assign lineRecoveryLost = lossReq;
  assign pllFrameRef8k = refReq;
endmodule

// ### bench/tcs_props.sv
// Port assertions for the transmit clock select block.
`timescale 1ns/1ps
module tcs_props
  import tcs_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // Bus.
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // Timing outputs.
  input wire tcs_timing_type timingSource,
  input wire logic lineCodeViolationPulse,
  input wire logic frameAlignPulse,
  input wire tcs_pindir_type pinOutputEnable,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  chk_lcv_single:
    assert property ($rose(lineCodeViolationPulse) |=> !lineCodeViolationPulse)
    else $error("violation pulse too long");
  chk_lcv_cause:
    assert property ($rose(lineCodeViolationPulse) |-> $past(s_axi_bvalid))
    else $error("violation pulse without write");
  chk_align_pll:
    assert property (frameAlignPulse |-> timingSource == TIMING_PLL
      || $past(timingSource) == TIMING_PLL)
    else $error("alignment outside PLL timing");
  chk_align_single:
    assert property (frameAlignPulse |=> !frameAlignPulse)
    else $error("alignment pulse too long");
  chk_ext_clkin:
    assert property (timingSource == TIMING_EXT |-> !pinOutputEnable.serialClk)
    else $error("clock pin driven under external timing");
  chk_read_wait:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_upper_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_write_block:
    assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  cov_lcv: cover property (lineCodeViolationPulse);
  cov_align: cover property (frameAlignPulse);
  cov_irq: cover property (irq);
endmodule
bind tcs_transmit_clock_select tcs_props u_props (.*);

// ### bench/tcs_transmit_clock_select_tb_top.sv
// Self-checking testbench for the transmit clock select block.
`timescale 1ns/1ps
module tcs_transmit_clock_select_tb_top
  import tcs_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = ZERO_WORD;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic lossReq = 1'b0;
  logic refReq = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdat;
  logic lineRecoveryLost, pllFrameRef8k, recoveredClk, serialClkIn, pllClk;
  logic t1Mode, lineCodeViolationPulse, frameAlignPulse, serialClkOut, irq;
  tcs_timing_type timingSource;
  tcs_pindir_type pinOutputEnable;
  int error_cnt = 0;
  int compares = 0;
  int lcvCnt = 0;
  int alnCnt = 0;

  always #20 sys_clk = ~sys_clk;
  tcs_transmit_clock_select uut (.*);
  tcs_far_model far (.*);
  always @(posedge sys_clk) begin
    lcvCnt <= lcvCnt + (lineCodeViolationPulse === 1'b1);
    alnCnt <= alnCnt + (frameAlignPulse === 1'b1);
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic hang();
    error_cnt++;
    close_out();
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 40) hang();
  endtask
  task automatic rd(input logic [15:0] a);
    int n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 40) hang();
  endtask
  task automatic pulse_ref();
    refReq <= 1'b1;
    cyc(5);
    refReq <= 1'b0;
    cyc(5);
  endtask

  task automatic t_reset();
    rd(CTRL_ADDR);
    chk("ctrl", rdat, 32'h0000_0011);
    chk("src", timingSource, TIMING_EXT);
    chk("oe", pinOutputEnable, 3'h3);
    chk("t1", t1Mode, 1'b0);
  endtask
  task automatic t_src();
    tcs_timing_type exp[4] = '{TIMING_LOOP, TIMING_EXT, TIMING_PLL, TIMING_LOOP};
    for (int c = 0; c < 4; c++) begin
      logic [31:0] d;
      d = {24'h00_0000, 1'b0, c[0], 4'b0100, c[1:0]};
      wr(CTRL_ADDR, d); // Reserved bits stay zero.
      cyc(3);
      chk("src", timingSource, exp[c]);
      chk("t1", t1Mode, c[0]);
      chk("clkoe", pinOutputEnable.serialClk, c != 1);
      rd(CTRL_ADDR);
      chk("back", rdat, d);
    end
  endtask
  task automatic t_lcv();
    int c0 = lcvCnt;
    wr(CTRL_ADDR, 32'h0000_0091);
    cyc(4);
    chk("lcv", lcvCnt - c0, 1);
    wr(CTRL_ADDR, 32'h0000_0091);
    cyc(4);
    chk("lcv", lcvCnt - c0, 1);
  endtask
  task automatic t_loss();
    wr(CTRL_ADDR, 32'h0000_0010);
    lossReq <= 1'b1;
    cyc(8);
    chk("fallback", timingSource, TIMING_PLL);
    rd(STATE_ADDR);
    chk("state", rdat, {29'h0000_0000, 1'b1, TIMING_PLL});
    rd(INT_STATUS_ADDR);
    chk("stat", rdat, 32'h0000_0020);
    chk("irq", irq, 1'b0);
    wr(INT_MASK_ADDR, 32'h0000_0020);
    cyc(3);
    chk("irq", irq, 1'b1);
    wr(INT_STATUS_ADDR, 32'h0000_0020);
    cyc(3);
    chk("irq", irq, 1'b0);
    lossReq <= 1'b0;
    cyc(8);
    chk("regain", timingSource, TIMING_LOOP);
    wr(CTRL_ADDR, ZERO_WORD);
    lossReq <= 1'b1;
    cyc(8);
    chk("noprot", timingSource, TIMING_LOOP);
    rd(INT_STATUS_ADDR);
    chk("stat", rdat, ZERO_WORD);
    lossReq <= 1'b0;
  endtask
  task automatic t_align();
    int c0 = alnCnt;
    wr(CTRL_ADDR, 32'h0000_0022);
    pulse_ref();
    chk("aln", alnCnt - c0, 1);
    wr(CTRL_ADDR, 32'h0000_0021);
    pulse_ref();
    chk("aln", alnCnt - c0, 1);
  endtask
  task automatic t_pins();
    wr(CTRL_ADDR, 32'h0000_0010);
    wr(SYNC_MUX_ADDR, 32'h0000_0010);
    cyc(3);
    chk("inv", pinOutputEnable, 3'h4);
    wr(BACKPLANE_ADDR, 32'h0000_0001);
    cyc(3);
    chk("hs", pinOutputEnable, 3'h0);
    chk("hsclk", serialClkOut, 1'b0);
    wr(16'h0200, ZERO_WORD);
    chk("werr", rsp, RESP_SLVERR);
    rd(16'h0200);
    chk("rerr", rsp, RESP_SLVERR);
    chk("rdat", rdat, ZERO_WORD);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    cyc(2);
    t_reset();
    t_src();
    t_lcv();
    t_loss();
    t_align();
    t_pins();
    close_out();
  end
  // Watchdog against a hung handshake.
  initial begin
    cyc(20000);
    hang();
  end
endmodule
